// *** src/arxcdr_rx.sv ***
`timescale 1ns/10ps
`default_nettype none
// Function
// [R01] Sixteen samples per bit, eight in double speed
// [R02] Falling edge while idle starts detection
// [R03] Start judged on samples 8-10 or 4-6
// [R04] Majority high start is noise, rejected
// [R05] Resynchronise phase on every valid start
// [R06] Per-bit state counter, sixteen or eight states
// [R07] Bit value is majority of centre samples
// [R08] Recover data, parity, first stop only
// [R09] Zero first stop sets frame error
// [R10] Next start accepted right after stop vote
// [R11] Data plus parity bits five to ten
// [R12] Remote rate error about two percent normal
// [R13] Remote rate error about 1.5 percent double
// [R14] Double speed halves oversampling divisor, async only
// [R15] Line passes two-stage synchroniser first
// [R16] Samples taken on baud generator tick

// ********************************************************************
// Frame FIFO
// ********************************************************************
module arxcdr_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    // Refuse depths the wrapping pointers cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad_depth
        $error("DEPTH must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic push, pop;

    // Flags and pointers
    always_comb
    begin
        in_ready_o = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
        out_valid_o = wr_ptr != rd_ptr;
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_wr_ptr = wr_ptr + (AW+1)'(push);
        next_rd_ptr = rd_ptr + (AW+1)'(pop);
    end

    // Storage and pointer registers, output read straight from storage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else if (ce_i)
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            if (push)
                mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    assign out_data_o = mem[rd_ptr[AW-1:0]];
endmodule : arxcdr_fifo

// ********************************************************************
// Receiver clock and data recovery
// ********************************************************************
module arxcdr_rx #(
    parameter int FIFO_DEPTH = arxcdr_pkg::FIFO_DEPTH_DEF
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Configuration
    input wire logic double_speed_select_i,
    input wire logic [15:0] baud_divisor_value_i,
    input wire logic [3:0] frame_bits_i,
    // Serial line
    input wire logic serial_in_line_i,
    // Frame output
    output logic frame_valid_o,
    input wire logic frame_ready_i,
    output logic [9:0] frame_data_o,
    output logic frame_error_flag_o,
    output logic overrun_o
);
    // Refuse a buffer too shallow to decouple the reader
    if (FIFO_DEPTH < 2)
    begin : g_bad_fifo
        $error("FIFO_DEPTH too small");
    end

    typedef enum logic [1:0] {ARX_IDLE, ARX_START, ARX_DATA, ARX_STOP}
        arxcdr_state_e;

    // Majority of three samples
    function automatic logic vote3(input logic [2:0] s);
        vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : vote3

    logic sync1, sync2, prev_line;
    logic [15:0] div_cnt, next_div_cnt;
    logic tick;
    arxcdr_state_e state, next_state;
    logic [3:0] phase, next_phase;
    logic [3:0] bit_idx, next_bit_idx;
    logic [2:0] votes, next_votes;
    logic [9:0] shreg, next_shreg;
    logic push, push_fe, next_push, next_push_fe, next_overrun;
    logic fifo_ready;
    logic [3:0] last_ph, vfirst;
    arxcdr_pkg::arxcdr_frame_s fin, fout;

    // Two-stage synchroniser; edge history is registered with the state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
        end
        else if (ce_i)
        begin
            sync1 <= serial_in_line_i; // R15
            sync2 <= sync1; // R15
        end
    end

    // Oversampling tick generator, divisor plus one clocks per sample
    always_comb
    begin
        tick = div_cnt == 16'h0000; // R16
        next_div_cnt = tick ? baud_divisor_value_i : div_cnt - 16'h0001;
    end

    // Mode dependent phase limits
    always_comb
    begin
        last_ph = double_speed_select_i ? 4'(arxcdr_pkg::SAMPLES_DOUBLE - 1)
                                        : 4'(arxcdr_pkg::SAMPLES_NORMAL - 1); // R01 R14
        vfirst = double_speed_select_i ? arxcdr_pkg::VOTE_FIRST_DOUBLE
                                       : arxcdr_pkg::VOTE_FIRST_NORMAL;
    end

    // Recovery state machine
    always_comb
    begin
        next_state = state;
        next_phase = phase;
        next_bit_idx = bit_idx;
        next_votes = votes;
        next_shreg = shreg;
        next_push = 1'b0;
        next_push_fe = push_fe;
        next_overrun = overrun_o;
        if (push)
            next_overrun = !fifo_ready;
        if (tick)
        begin
            case (state)
                ARX_IDLE:
                begin
                    if (prev_line && !sync2) // R02
                    begin
                        next_state = ARX_START;
                        // This tick is sample one, the next is sample two
                        next_phase = 4'h2; // R02
                        next_votes = 3'h0;
                    end
                end
                ARX_START:
                begin
                    next_phase = phase + 4'h1;
                    if (phase >= vfirst && phase <= vfirst + 4'h2)
                        next_votes = {votes[1:0], sync2}; // R03
                    if (phase == vfirst + 4'h2)
                    begin
                        if (vote3({votes[1:0], sync2})) // R04
                            next_state = ARX_IDLE;
                        else
                        begin
                            next_state = ARX_DATA; // R05
                            next_bit_idx = 4'h0;
                        end
                    end
                end
                ARX_DATA, ARX_STOP:
                begin
                    // Phase counts through one bit period
                    next_phase = (phase == last_ph) ? 4'h0 : phase + 4'h1; // R06
                    if (phase >= vfirst && phase <= vfirst + 4'h2)
                        next_votes = {votes[1:0], sync2};
                    if (phase == vfirst + 4'h2)
                    begin
                        if (state == ARX_DATA)
                        begin
                            next_shreg = {vote3({votes[1:0], sync2}), shreg[9:1]}; // R07
                            next_bit_idx = bit_idx + 4'h1;
                            if (bit_idx + 4'h1 == frame_bits_i) // R08 R11
                                next_state = ARX_STOP;
                        end
                        else
                        begin
                            next_push_fe = !vote3({votes[1:0], sync2}); // R09
                            next_push = 1'b1;
                            next_state = ARX_IDLE; // R10 R08
                        end
                    end
                end
                default: next_state = ARX_IDLE;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_cnt <= arxcdr_pkg::DIVISOR_RESET;
            prev_line <= 1'b1;
            state <= ARX_IDLE;
            phase <= 4'h0;
            bit_idx <= 4'h0;
            votes <= 3'h0;
            shreg <= 10'h000;
            push <= 1'b0;
            push_fe <= 1'b0;
            overrun_o <= 1'b0;
        end
        else if (ce_i)
        begin
            div_cnt <= next_div_cnt;
            if (tick)
                prev_line <= sync2;
            state <= next_state;
            phase <= next_phase;
            bit_idx <= next_bit_idx;
            votes <= next_votes;
            shreg <= next_shreg;
            push <= next_push;
            push_fe <= next_push_fe;
            overrun_o <= next_overrun;
        end
    end

    // Right-justify the frame into the low bits
    always_comb
    begin
        fin.bits = shreg >> (4'd10 - frame_bits_i);
        fin.frame_error_flag = push_fe;
    end

    arxcdr_fifo #(
        .WIDTH(11),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_valid_i(push),
        .in_ready_o(fifo_ready),
        .in_data_i(fin),
        .out_valid_o(frame_valid_o),
        .out_ready_i(frame_ready_i),
        .out_data_o(fout)
    );

    assign frame_data_o = fout.bits;
    assign frame_error_flag_o = fout.frame_error_flag;
endmodule : arxcdr_rx
`default_nettype wire

// *** src/arxcdr_pkg.sv ***
`default_nettype none
package arxcdr_pkg;

    // ****************************************************************
    // Sampling constants
    // ****************************************************************
    localparam int SAMPLES_NORMAL = 16;
    localparam int SAMPLES_DOUBLE = 8;
    localparam logic [3:0] VOTE_FIRST_NORMAL = 4'h8;
    localparam logic [3:0] VOTE_FIRST_DOUBLE = 4'h4;
    localparam int BITS_MIN = 5;
    localparam int BITS_MAX = 10;
    localparam int FIFO_DEPTH_DEF = 16;
    localparam logic [15:0] DIVISOR_RESET = 16'h0000;
    localparam int CLK_HZ = 10_000_000;

    // ****************************************************************
    // Received frame carrier
    // ****************************************************************
    typedef struct packed {
        logic [9:0] bits;
        logic frame_error_flag;
    } arxcdr_frame_s;

endpackage : arxcdr_pkg
`default_nettype wire

// *** verif/arxcdr_rx_props.sv ***
`timescale 1ns/10ps
`default_nettype none
// ********
// Receiver port checks
// ********
module arxcdr_rx_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Configuration and line
    input wire logic double_speed_select_i,
    input wire logic [15:0] baud_divisor_value_i,
    input wire logic [3:0] frame_bits_i,
    input wire logic serial_in_line_i,
    // Frame side
    input wire logic frame_valid_o,
    input wire logic frame_ready_i,
    input wire logic [9:0] frame_data_o,
    input wire logic frame_error_flag_o,
    input wire logic overrun_o
);
    logic [31:0] hi_cnt;
    logic [31:0] next_hi_cnt;
    logic [31:0] lim;
    // Enabled cycles since the line was last low
    always_comb next_hi_cnt = serial_in_line_i ? hi_cnt + {31'h0, ce_i}
        : 32'h0;
    always_comb lim = 32'hc0 * ({16'h0, baud_divisor_value_i} + 32'h1) + 32'h8;
    always_ff @(posedge clk_i) hi_cnt <= rst_i ? 32'h0 : next_hi_cnt;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_reset_clear: assert property (disable iff (1'b0) rst_i && ce_i |=>
        !frame_valid_o && !overrun_o) else $error("outputs not cleared");
    a_head_hold: assert property (frame_valid_o &&
        !(frame_ready_i && ce_i) |=> frame_valid_o && $stable(frame_data_o)
        && $stable(frame_error_flag_o)) else $error("head frame moved");
    a_ce_freeze: assert property (!ce_i |=> $stable(frame_valid_o)
        && $stable(overrun_o)) else $error("state moved without enable");
    a_data_width: assert property (frame_valid_o |->
        (frame_data_o >> frame_bits_i) == 10'h0) else $error("bits too wide");
    a_no_phantom: assert property (hi_cnt > lim |->
        !$rose(frame_valid_o)) else $error("frame from idle line");
    a_ovr_rise: assert property ($rose(overrun_o) |-> frame_valid_o)
        else $error("overrun with room left");
    a_ovr_fall: assert property ($fell(overrun_o) |-> frame_valid_o)
        else $error("overrun cleared without push");
    a_pop_only: assert property ($fell(frame_valid_o) |->
        $past(frame_ready_i) && $past(ce_i)) else $error("frame lost");
endmodule : arxcdr_rx_props
bind arxcdr_rx arxcdr_rx_props chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .double_speed_select_i(double_speed_select_i),
    .baud_divisor_value_i(baud_divisor_value_i),
    .frame_bits_i(frame_bits_i), .serial_in_line_i(serial_in_line_i),
    .frame_valid_o(frame_valid_o), .frame_ready_i(frame_ready_i),
    .frame_data_o(frame_data_o), .frame_error_flag_o(frame_error_flag_o),
    .overrun_o(overrun_o));
`default_nettype wire

// *** verif/arxcdr_tx_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ********
// Remote serial transmitter
// ********
module arxcdr_tx_model (
    // Clock
    input wire logic clk_i,
    // Serial line
    output var logic line_o
);
    initial line_o = 1'b1; // Idle high
    // Hold one level for n clocks from a falling edge
    task automatic hold(input logic v, input int n);
        line_o = v;
        repeat (n) @(negedge clk_i);
    endtask : hold
    // Frame LSB first with an optional lone bad sample per data bit
    task automatic send(input logic [9:0] d, input int n, input logic stop,
        input int per, input int sw, input int sl);
        int c;
        c = per / 2 - sw;
        hold(1'b0, per);
        for (int i = 0; i < n; i++)
        begin
            hold(d[i], c);
            if (sw > 0) hold(!d[i], sw);
            hold(d[i], per - c - sw);
        end
        hold(stop, sl);
        // A bad stop returns high for at least one clock before release
        if (!stop) hold(1'b1, 1);
    endtask : send
endmodule : arxcdr_tx_model
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
// ********
// Receiver bench
// ********
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic dbl = 1'b0;
    logic [15:0] div = 16'h3;
    logic [3:0] nbits = 4'h8;
    logic ready = 1'b1;
    wire logic line;
    logic valid, ferr, ovr;
    logic [9:0] data;
    logic [10:0] exp_q [$];
    int fail_count = 0;
    int checks = 0;
    int per = 65;
    always #50 clk_i = !clk_i;
    arxcdr_rx dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .double_speed_select_i(dbl), .baud_divisor_value_i(div),
        .frame_bits_i(nbits), .serial_in_line_i(line),
        .frame_valid_o(valid), .frame_ready_i(ready),
        .frame_data_o(data), .frame_error_flag_o(ferr), .overrun_o(ovr));
    arxcdr_tx_model tx_u (.clk_i(clk_i), .line_o(line));
    // Compare and count
    task automatic check(input logic [10:0] seen, input logic [10:0] want);
        checks++;
        if (seen !== want)
        begin
            fail_count++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    // Send a random frame and note what should come out
    task automatic frame(input logic stop, input int sw, input int sl,
        input bit note);
        logic [9:0] d;
        d = 10'($urandom) & ((10'h1 << nbits) - 10'h1);
        if (note) exp_q.push_back({d, !stop});
        tx_u.send(d, int'(nbits), stop, per, sw, sl);
    endtask : frame
    // Wait for every noted frame to be taken
    task automatic drain;
        int n;
        n = 0;
        while (exp_q.size() > 0 && n < 3000)
        begin
            @(negedge clk_i);
            n++;
        end
        check(11'(exp_q.size()), 11'h0);
    endtask : drain
    task automatic results;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    // Each frame taken is checked against the oldest note
    always @(posedge clk_i)
        if (valid === 1'b1 && ready && ce_i && !rst_i)
            check({data, ferr}, exp_q.size() > 0 ? exp_q.pop_front()
                : 11'hxxx);
    // Give up on a hang
    initial
    begin
        repeat (60000) @(posedge clk_i);
        fail_count++;
        results();
    end
    // Main sequence
    initial
    begin
        void'($urandom(32'hb9f78e94));
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        @(negedge clk_i);
        // All sizes, both modes, short stop in normal mode, bad stop, spike
        for (int m = 0; m < 2; m++)
        begin
            dbl = m[0];
            per = m ? 32 : 65;
            for (int b = 5; b <= 10; b++)
            begin
                nbits = 4'(b);
                frame(1'b1, 4, m ? per : 52, 1'b1);
                frame(1'b0, 0, per, 1'b1);
                tx_u.hold(1'b1, per);
                tx_u.hold(1'b0, m ? 6 : 12);
                tx_u.hold(1'b1, per);
                drain();
            end
        end
        // Overfill with the reader stalled, freeze, then drain
        ready = 1'b0;
        for (int k = 0; k < 17; k++)
            frame(1'b1, 0, per, k < 16);
        check({10'h0, ovr}, 11'h1);
        ce_i = 1'b0;
        ready = 1'b1;
        repeat (5) @(negedge clk_i);
        check({10'h0, valid}, 11'h1);
        ce_i = 1'b1;
        drain();
        frame(1'b1, 0, per, 1'b1);
        drain();
        check({10'h0, ovr}, 11'h0);
        results();
    end
endmodule : testbench
`default_nettype wire
